// >>> shared/dscp_map_pkg.sv
package dscp_map_pkg;

   // Register word indices; byte address on the bus is four times the index
   localparam logic [9:0] IDX_CODES_00_03 = 10'h090;
   localparam logic [9:0] IDX_CODES_04_07 = 10'h091;
   localparam logic [9:0] IDX_CODES_08_0B = 10'h092;
   localparam logic [9:0] IDX_CODES_0C_0F = 10'h093;
   localparam logic [9:0] IDX_CODES_10_13 = 10'h094;
   localparam logic [9:0] IDX_CODES_14_17 = 10'h095;
   localparam logic [9:0] IDX_CODES_18_1B = 10'h096;
   localparam logic [9:0] IDX_CODES_1C_1F = 10'h097;
   localparam logic [9:0] IDX_CODES_20_23 = 10'h098;
   // Lookup status register, read only
   localparam logic [9:0] IDX_LOOKUP_STATUS = 10'h0F0;

   // Bus geometry
   localparam int WB_ADR_W = 12;
   localparam int WB_DAT_W = 32;
   localparam int WB_SEL_W = 4;

   // Map geometry
   localparam int MAP_CODES     = 36;
   localparam int MAP_FIELD_W   = 2;
   localparam int MAP_PER_REG   = 4;
   localparam int MAP_REG_W     = 8;
   localparam int MAP_ALL_CODES = 64;
   localparam int CODE_W        = 6;

   // Position of the code inside the type-of-service / traffic-class octet
   localparam int CODE_MSB = 7;
   localparam int CODE_LSB = 2;

   // Status register fields
   localparam int STAT_CODE_LSB = 2;
   localparam int STAT_PRIO_LSB = 0;

   // Reset values
   localparam logic [7:0] MAP_REG_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET  = 8'h00;

   // Bus slave states
   typedef enum logic [0:0] {
      BUS_IDLE,
      BUS_ACK
   } bus_state_e;

   // Frame presented for classification
   typedef struct packed {
      logic       valid;
      logic       is_ip;
      logic [7:0] tos;
   } frame_req_s;

   // Classification answer
   typedef struct packed {
      logic                   valid;
      logic                   hit;
      logic [MAP_FIELD_W-1:0] prio;
   } prio_res_s;

endpackage : dscp_map_pkg

// >>> rtl/dscp_entry_select.sv
`timescale 1ns/1ps

module dscp_entry_select
   import dscp_map_pkg::*;
#(
   parameter int NUM_CODES = MAP_CODES
)
(
   // Stored map, code c in bits 2c+1..2c
   input  wire logic [NUM_CODES*MAP_FIELD_W-1:0] map_i,
   // Selecting code
   input  wire logic [CODE_W-1:0]                code_i,
   // Selected entry
   output logic      [MAP_FIELD_W-1:0]           prio_o,
   output logic                                  hit_o
);

   logic [MAP_FIELD_W-1:0] entry   [MAP_ALL_CODES];
   logic [MAP_ALL_CODES-1:0] present;

   initial
   begin
      if (NUM_CODES < 1 || NUM_CODES > MAP_ALL_CODES)
      begin
         $error("dscp_entry_select: NUM_CODES out of range");
      end
   end

   // Every one of the 64 codes has a slot; codes held elsewhere read empty
   for (genvar i = 0; i < MAP_ALL_CODES; i++)
   begin : g_entry
      if (i < NUM_CODES)
      begin : g_held
         assign entry[i]   = map_i[i*MAP_FIELD_W +: MAP_FIELD_W];
         assign present[i] = 1'b1;
      end
      else
      begin : g_absent
         assign entry[i]   = '0;
         assign present[i] = 1'b0;
      end
   end

   // Fully decoded: exactly one slot answers a given code
   assign prio_o = entry[code_i];
   assign hit_o  = present[code_i];

endmodule : dscp_entry_select

// >>> rtl/ip_dscp_priority_map_low.sv
`timescale 1ns/1ps

// Operation
// - Bits 7 down to 2 of the IP type-of-service or traffic-class octet form the 6-bit code.
// - The 2-bit value in the entry chosen by the code is the frame priority, code 0x00 in bits 1-0 at 0x90.
// - Entries sit four to a byte register in rising code order, so 0x91 holds 0x04 to 0x07 with 0x07 in bits 7-6.
// - The register at 0x94 holds codes 0x10 to 0x13, with 0x13 in its top two bits.
// - The register at 0x98 holds codes 0x20 to 0x23, with 0x20 in bits 1-0, and ends this part.
// - Every map field is read/write from software and resets to 00.
// - The code is fully decoded into one of 64 slots; codes 0x00 to 0x23 give their stored value, higher codes give no hit.

module ip_dscp_priority_map_low
   import dscp_map_pkg::*;
#(
   parameter int NUM_CODES = MAP_CODES
)
(
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,

   // Wishbone classic slave
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [WB_ADR_W-1:0] wb_adr_i,
   input  wire logic [WB_SEL_W-1:0] wb_sel_i,
   input  wire logic [WB_DAT_W-1:0] wb_dat_i,
   output logic      [WB_DAT_W-1:0] wb_dat_o,
   output logic                     wb_ack_o,

   // Classification side
   input  wire logic                diffserv_en_i,
   input  wire frame_req_s          frame_i,
   output prio_res_s                prio_o
);

   localparam int NUM_REGS = (NUM_CODES + MAP_PER_REG - 1) / MAP_PER_REG;
   localparam int MAP_W    = NUM_REGS * MAP_REG_W;

   // Whole state of the block in one word
   typedef struct packed {
      bus_state_e          bus;
      logic                ack;
      logic [WB_DAT_W-1:0] rdata;
      logic [MAP_W-1:0]    map;
      logic [7:0]          status;
      prio_res_s           res;
   } state_s;

   state_s state;
   state_s next_state;

   // Decode results
   logic [WB_ADR_W-3:0]    word_idx;
   logic                   map_hit;
   logic [3:0]             map_pos;
   logic                   stat_hit;
   logic [CODE_W-1:0]      code;
   logic [MAP_FIELD_W-1:0] sel_prio;
   logic                   sel_present;
   logic                   apply;

   initial
   begin
      // The register layout only covers the nine registers of this part
      if (NUM_CODES < 1 || NUM_CODES > MAP_CODES)
      begin
         $error("ip_dscp_priority_map_low: NUM_CODES out of range");
      end
   end

   // Word index of the access; byte bits are ignored
   assign word_idx = wb_adr_i[WB_ADR_W-1:2];

   // Register decode, each map index names one byte of the map; 0xF0 selects status
   always_comb
   begin
      map_hit  = 1'b1;
      map_pos  = 4'h0;
      stat_hit = 1'b0;
      unique case (word_idx)
         IDX_CODES_00_03:   map_pos = 4'h0;  // Code 0x00 in bits 1-0
         IDX_CODES_04_07:   map_pos = 4'h1;  // Codes 0x04..0x07
         IDX_CODES_08_0B:   map_pos = 4'h2;
         IDX_CODES_0C_0F:   map_pos = 4'h3;
         IDX_CODES_10_13:   map_pos = 4'h4;  // Codes 0x10..0x13
         IDX_CODES_14_17:   map_pos = 4'h5;
         IDX_CODES_18_1B:   map_pos = 4'h6;
         IDX_CODES_1C_1F:   map_pos = 4'h7;
         IDX_CODES_20_23:   map_pos = 4'h8;  // Codes 0x20..0x23, last one
         IDX_LOOKUP_STATUS:
         begin
            map_hit  = 1'b0;
            stat_hit = 1'b1;
         end
         default:
         begin
            map_hit = 1'b0;
         end
      endcase
      // A shortened table leaves its upper registers unmapped
      if (32'(map_pos) >= NUM_REGS)
      begin
         map_hit = 1'b0;
      end
   end

   // The code is the upper six bits of the octet
   assign code = frame_i.tos[CODE_MSB:CODE_LSB];

   // Other frames keep whatever priority other sources give them
   assign apply = frame_i.valid & frame_i.is_ip & diffserv_en_i;

   // Map index c lives at bits 2c+1..2c, so byte r holds codes 4r..4r+3
   dscp_entry_select #(
      .NUM_CODES (NUM_REGS * MAP_PER_REG)
   ) u_select (
      .map_i  (state.map),
      .code_i (code),
      .prio_o (sel_prio),
      .hit_o  (sel_present)
   );

   // Next state of bus slave, map, status and lookup result
   always_comb
   begin
      next_state = state;

      // Bus slave: answer every request one cycle after it is seen
      unique case (state.bus)
         BUS_IDLE:
         begin
            next_state.ack = 1'b0;
            if (wb_cyc_i && wb_stb_i)
            begin
               next_state.bus   = BUS_ACK;
               next_state.ack   = 1'b1;
               next_state.rdata = '0;
               if (wb_we_i)
               begin
                  // Only lane 0 carries a map byte; upper lanes are dropped
                  if (map_hit && wb_sel_i[0])
                  begin
                     next_state.map[map_pos*MAP_REG_W +: MAP_REG_W] =
                        wb_dat_i[MAP_REG_W-1:0];
                  end
               end
               else if (map_hit)
               begin
                  next_state.rdata[MAP_REG_W-1:0] =
                     state.map[map_pos*MAP_REG_W +: MAP_REG_W];
               end
               else if (stat_hit)
               begin
                  next_state.rdata[7:0] = state.status;
               end
               // Unmapped addresses are acknowledged and read zero
            end
         end
         BUS_ACK:
         begin
            // Drop ack after one cycle; the master releases meanwhile
            next_state.bus = BUS_IDLE;
            next_state.ack = 1'b0;
         end
      endcase

      // Lookup result, registered so outputs come straight from flops
      next_state.res.valid = frame_i.valid;
      next_state.res.hit   = 1'b0;
      next_state.res.prio  = '0;
      if (apply && sel_present && 32'(code) < NUM_CODES)
      begin
         next_state.res.hit  = 1'b1;
         next_state.res.prio = sel_prio;
         next_state.status   = {code, sel_prio};
      end
   end

   // Single state register; synchronous reset clears the map to 00
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state.bus    <= BUS_IDLE;
         state.ack    <= 1'b0;
         state.rdata  <= '0;
         state.map    <= {NUM_REGS{MAP_REG_RESET}};
         state.status <= STATUS_RESET;
         state.res    <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Outputs straight from the state register
   assign wb_ack_o = state.ack;
   assign wb_dat_o = state.rdata;
   assign prio_o   = state.res;

endmodule : ip_dscp_priority_map_low

// >>> verif/dscp_map_chk_sva.sv
`timescale 1ns/1ps

module dscp_map_chk
   import dscp_map_pkg::*;
#(
   parameter int NUM_CODES = MAP_CODES
)
(
   input wire logic                clk_i,
   input wire logic                rst_i,
   input wire logic                wb_cyc_i,
   input wire logic                wb_stb_i,
   input wire logic                wb_we_i,
   input wire logic [WB_ADR_W-1:0] wb_adr_i,
   input wire logic [WB_SEL_W-1:0] wb_sel_i,
   input wire logic [WB_DAT_W-1:0] wb_dat_i,
   input wire logic [WB_DAT_W-1:0] wb_dat_o,
   input wire logic                wb_ack_o,
   input wire logic                diffserv_en_i,
   input wire frame_req_s          frame_i,
   input wire prio_res_s           prio_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Request taken by an idle slave
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // Frame that must go through the map
   sequence s_elig;
      frame_i.valid && frame_i.is_ip && diffserv_en_i && frame_i.tos[7:2] < NUM_CODES;
   endsequence

   chk_ack_pulse: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single pulse one cycle after request");
   chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   chk_dat_byte: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data above byte not zero");
   chk_past_table: assert property (s_take ##0 (!wb_we_i && wb_adr_i[11:2] > IDX_CODES_20_23
      && wb_adr_i[11:2] < IDX_LOOKUP_STATUS) |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_lookup_hit: assert property (s_elig |=> prio_o.valid && prio_o.hit)
      else $error("eligible frame missed the map");
   chk_lookup_skip: assert property (frame_i.valid && !(frame_i.is_ip && diffserv_en_i)
      |=> prio_o.valid && !prio_o.hit && prio_o.prio == 2'b00)
      else $error("ineligible frame used the map");
   chk_valid_copy: assert property (!frame_i.valid |=> !prio_o.valid)
      else $error("answer without frame");
   chk_hit_cause: assert property (prio_o.hit |-> $past(frame_i.is_ip && diffserv_en_i))
      else $error("hit without enabled IP frame");
   chk_code_range: assert property (frame_i.valid && frame_i.tos[7:2] >= NUM_CODES
      |=> !prio_o.hit)
      else $error("code beyond table gave a hit");
endmodule : dscp_map_chk

bind ip_dscp_priority_map_low dscp_map_chk #(.NUM_CODES(NUM_CODES)) i_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .diffserv_en_i(diffserv_en_i),
   .frame_i(frame_i), .prio_o(prio_o));

// >>> verif/ip_dscp_priority_map_low_tb_top.sv
`timescale 1ns/1ps

module ip_dscp_priority_map_low_tb_top
   import dscp_map_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        req = 1'b0;
   logic        we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic        en = 1'b0;
   frame_req_s  frm = '0;
   prio_res_s   res;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   ip_dscp_priority_map_low i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .diffserv_en_i(en), .frame_i(frm), .prio_o(res));

   // 25 MHz clock
   always #20 clk_i = ~clk_i;

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         final_report();
      end
   end

   // Distinct byte per register so a swapped field shows
   function automatic logic [7:0] pat(input int r);
      return 8'h1B ^ (8'h4D * r[7:0]);
   endfunction : pat

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One classic cycle; data taken and request released at the edge that samples ack high
   task automatic wb(input logic w, input int r, input logic [7:0] d, output logic [31:0] q);
      @(posedge clk_i);
      req <= 1'b1;
      we <= w;
      adr <= 12'h240 + 12'(4 * r);
      dat <= {24'h0, d};
      do
      begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      req <= 1'b0;
   endtask : wb

   // Reset values, index 9 is just past the table
   task automatic t_reset();
      logic [31:0] q;
      for (int r = 0; r < 10; r++)
      begin
         wb(1'b0, r, 8'h00, q);
         chk("reset value", 32'h0, q);
      end
   endtask : t_reset

   // Write every register and the first unmapped one, then read all back
   task automatic t_rw();
      logic [31:0] q;
      for (int r = 0; r < 10; r++)
         wb(1'b1, r, pat(r), q);
      for (int r = 0; r < 10; r++)
      begin
         wb(1'b0, r, 8'h00, q);
         chk("readback", (r < 9) ? {24'h0, pat(r)} : 32'h0, q);
      end
   endtask : t_rw

   // All 64 codes: eligible, non-IP, enable low; low tos bits set to show they are ignored
   task automatic t_lookup();
      logic        h;
      logic [7:0]  p;
      logic [31:0] q;
      for (int m = 0; m < 3; m++)
         for (int c = 0; c < 64; c++)
         begin
            @(posedge clk_i);
            frm <= '{1'b1, m != 1, {c[5:0], 2'b11}};
            en <= (m != 2);
            @(posedge clk_i);
            frm.valid <= 1'b0;
            #1;
            h = (m == 0) && (c < 36);
            p = h ? (pat(c / 4) >> (2 * (c % 4))) & 8'h03 : 8'h00;
            chk("lookup", {28'h0, 1'b1, h, p[1:0]}, {28'h0, res});
         end
      // Status keeps the last hit: code 0x23 with the top field of the last register
      wb(1'b0, 96, 8'h00, q);
      chk("status", 32'h0000008D, q);
   endtask : t_lookup

   task automatic final_report();
      $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_rw();
      t_lookup();
      final_report();
   end
endmodule : ip_dscp_priority_map_low_tb_top
